// ---- bench/usfs_top_tb_top.sv ----
// Self-checking testbench of the usage and security fault status unit
`timescale 1ns/1ps
module usfs_top_tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    usfs_pkg::usfs_misuse_type misuse_i = '0;
    usfs_pkg::usfs_secure_type secure_i = '0;
    logic prot_ctrl_err_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, misuse_exc, sec_exc, bus_exc, esc_exc, irq_o, sec_exc_ns;
    int bad_count = 0;
    int tests_run = 0;
    logic [32:0] rd_q[$];
    logic [3:0] exc_q[$];
    logic [15:0] lfsr_v = 16'h0037;
    logic sec_seen_d = 1'b0;

    initial forever #2 clk_i = ~clk_i;

    usfs_top dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .misuse_i(misuse_i),
        .secure_i(secure_i), .prot_ctrl_err_i(prot_ctrl_err_i),
        .misuse_exception_o(misuse_exc), .security_violation_exception_o(sec_exc),
        .bus_error_exception_o(bus_exc), .escalated_fault_exception_o(esc_exc),
        .irq_o(irq_o)
    );

    // Same stimulus, built without the security extension
    usfs_top #(.SEC_IMPL(1'b0)) dut_nosec_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(),
        .pready_o(), .pslverr_o(), .misuse_i(misuse_i), .secure_i(secure_i),
        .prot_ctrl_err_i(prot_ctrl_err_i), .misuse_exception_o(),
        .security_violation_exception_o(sec_exc_ns), .bus_error_exception_o(),
        .escalated_fault_exception_o(), .irq_o()
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t: no ready on bus", $time);
            give_verdict();
        end else begin
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
        rd_q.push_back({err, exp});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Expected exception vector: misuse, security, bus error, escalated
    task automatic fault(input logic [8:0] m, input logic [2:0] s, input logic p,
                         input logic [3:0] exp);
        @(posedge clk_i);
        misuse_i <= m;
        secure_i <= s;
        prot_ctrl_err_i <= p;
        if (exp != 4'h0) exc_q.push_back(exp);
        @(posedge clk_i);
        misuse_i <= '0;
        secure_i <= '0;
        prot_ctrl_err_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            if (rd_q.size() == 0) begin
                bad_count++;
                $display("ERROR %0t: unexpected read answer", $time);
            end else begin
                check({pslverr_o, prdata_o}, rd_q.pop_front());
            end
        end
        if (!sys_rst_i && {misuse_exc, sec_exc, bus_exc, esc_exc} !== 4'h0) begin
            if (exc_q.size() == 0) begin
                bad_count++;
                $display("ERROR %0t: unexpected exception pulse", $time);
            end else begin
                check({29'h0, misuse_exc, sec_exc, bus_exc, esc_exc}, {29'h0, exc_q.pop_front()});
            end
        end
        if (sec_seen_d) check({32'h0, sec_exc_ns}, 33'h0);
        sec_seen_d <= (secure_i != 3'b000);
    end

    localparam logic [31:0] MIS_EN = 32'h1 << usfs_pkg::BIT_MISUSE_EN;
    localparam logic [31:0] SEC_EN = 32'h1 << usfs_pkg::BIT_SEC_EN;
    logic [8:0] cvec [8] = '{9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h001, 9'h006};
    int cbit [8] = '{24, 20, 19, 18, 17, 17, 16, -1};
    logic [11:0] roff [3] = '{usfs_pkg::OFF_HANDLER_CTRL, usfs_pkg::OFF_CTRL, usfs_pkg::OFF_IRQ_EN};
    logic [31:0] rmsk [3] = '{MIS_EN | SEC_EN, 32'h0000_0010, 32'h0000_000f};

    initial begin
        logic [31:0] r;
        logic [31:0] e;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h0);
        for (int i = 0; i < 3; i++) rd(roff[i], 32'h0);
        rd(usfs_pkg::OFF_IRQ_STAT, 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 3; i++) begin
                lfsr_v = lfsr_next(lfsr_v);
                r = {lfsr_v, ~lfsr_v};
                wr(roff[i], r);
                rd(roff[i], r & rmsk[i]);
            end
        end
        wr(usfs_pkg::OFF_HANDLER_CTRL, 32'h0);
        wr(usfs_pkg::OFF_CTRL, 32'h0);
        wr(usfs_pkg::OFF_IRQ_EN, 32'h0);
        $display("test enable registers done");
        // Divide by zero is ignored while the trap enable is clear
        fault(9'h100, 3'b000, 1'b0, 4'h0);
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h0);
        wr(usfs_pkg::OFF_CTRL, 32'h1 << usfs_pkg::BIT_TRAP_EN);
        fault(9'h100, 3'b000, 1'b0, 4'h1);
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h1 << 25);
        wr(usfs_pkg::OFF_FAULT_STAT, 32'h1 << 25);
        $display("test divide trap done");
        for (int en = 0; en < 2; en++) begin
            wr(usfs_pkg::OFF_HANDLER_CTRL, en ? MIS_EN : 32'h0);
            for (int i = 0; i < 8; i++) begin
                e = (cbit[i] < 0) ? 32'h0 : (32'h1 << cbit[i]);
                fault(cvec[i], 3'b000, 1'b0, (cbit[i] < 0) ? 4'h0 : (en ? 4'h8 : 4'h1));
                rd(usfs_pkg::OFF_FAULT_STAT, e);
                wr(usfs_pkg::OFF_FAULT_STAT, ~e);
                rd(usfs_pkg::OFF_FAULT_STAT, e);
                wr(usfs_pkg::OFF_FAULT_STAT, e);
                rd(usfs_pkg::OFF_FAULT_STAT, 32'h0);
            end
        end
        // Clear and new event in the same cycle: the event must survive
        fork
            wr(usfs_pkg::OFF_FAULT_STAT, 32'h1 << 24);
            begin
                @(posedge clk_i);
                fault(9'h080, 3'b000, 1'b0, 4'h8);
            end
        join
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h1 << 24);
        wr(usfs_pkg::OFF_FAULT_STAT, 32'h1 << 24);
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h0);
        $display("test cause flags done");
        wr(usfs_pkg::OFF_HANDLER_CTRL, SEC_EN);
        fault(9'h000, 3'b100, 1'b0, 4'h4);
        fault(9'h000, 3'b010, 1'b0, 4'h4);
        fault(9'h000, 3'b001, 1'b0, 4'h4);
        wr(usfs_pkg::OFF_HANDLER_CTRL, 32'h0);
        fault(9'h000, 3'b010, 1'b0, 4'h1);
        fault(9'h000, 3'b000, 1'b1, 4'h2);
        rd(usfs_pkg::OFF_FAULT_STAT, 32'h0);
        $display("test security faults done");
        rd(usfs_pkg::OFF_IRQ_STAT, 32'h0000_000f);
        wr(usfs_pkg::OFF_IRQ_STAT, 32'h0);
        rd(usfs_pkg::OFF_IRQ_STAT, 32'h0000_000f);
        rd(usfs_pkg::OFF_IRQ_CLR, 32'h0);
        rd(12'h018, 32'h0, 1'b1);
        check({32'h0, irq_o}, 33'h0);
        wr(usfs_pkg::OFF_IRQ_EN, 32'h0000_0004);
        repeat (2) @(posedge clk_i);
        check({32'h0, irq_o}, 33'h1);
        wr(usfs_pkg::OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk_i);
        check({32'h0, irq_o}, 33'h0);
        wr(usfs_pkg::OFF_IRQ_CLR, 32'h0000_000f);
        rd(usfs_pkg::OFF_IRQ_STAT, 32'h0);
        wr(usfs_pkg::OFF_IRQ_EN, 32'h0000_000f);
        wr(usfs_pkg::OFF_HANDLER_CTRL, MIS_EN);
        fault(9'h040, 3'b000, 1'b0, 4'h8);
        check({32'h0, irq_o}, 33'h1);
        rd(usfs_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        $display("test interrupt done");
        repeat (4) @(posedge clk_i);
        check({1'b0, 32'(rd_q.size())}, 33'h0);
        check({1'b0, 32'(exc_q.size())}, 33'h0);
        give_verdict();
    end
endmodule

// ---- core/usfs_pkg.sv ----
// Constants and carrier types of the usage and security fault status block
package usfs_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [11:0] OFF_FAULT_STAT = 12'h000;
    localparam logic [11:0] OFF_HANDLER_CTRL = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h00c;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h010;
    localparam logic [11:0] OFF_IRQ_EN = 12'h014;
    // Cause flags, index order in the flag vector
    localparam int NCAUSE = 7;
    localparam int CI_DIVZ = 0;
    localparam int CI_UNAL = 1;
    localparam int CI_STACK = 2;
    localparam int CI_COPROC = 3;
    localparam int CI_BADRET = 4;
    localparam int CI_STATE = 5;
    localparam int CI_UNDEF = 6;
    localparam int CAUSE_BIT [NCAUSE] = '{25, 24, 20, 19, 18, 17, 16};
    // Enable fields
    localparam int BIT_MISUSE_EN = 18;
    localparam int BIT_SEC_EN = 19;
    localparam int BIT_TRAP_EN = 4;
    // Interrupt status layout
    localparam int NIRQ = 4;
    localparam int IRQ_MISUSE = 0;
    localparam int IRQ_SECURE = 1;
    localparam int IRQ_ESCAL = 2;
    localparam int IRQ_BUSERR = 3;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic div_zero;
        logic unaligned_multi;
        logic stack_limit;
        logic coproc_absent;
        logic bad_return;
        logic bad_state;
        logic cont_bits_nonzero;
        logic next_is_multi;
        logic undefined_opcode;
    } usfs_misuse_type;

    typedef struct packed {
        logic perm_violation;
        logic bad_entry;
        logic integrity_fail;
    } usfs_secure_type;
endpackage

// ---- core/usfs_sticky.sv ----
// Sticky flag that hardware sets and software clears by writing a one
`timescale 1ns/1ps
module usfs_sticky (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_o <= 1'b0;
        end else if (set_i) begin
            q_o <= 1'b1;
        end else if (clr_i) begin
            q_o <= 1'b0;
        end
    end
endmodule

// ---- core/usfs_top.sv ----
// Usage and security fault status unit with APB register access
`timescale 1ns/1ps
module usfs_top #(
    parameter bit SEC_IMPL = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [usfs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [usfs_pkg::DATA_W-1:0] pwdata_i,
    output logic [usfs_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire usfs_pkg::usfs_misuse_type misuse_i,
    input wire usfs_pkg::usfs_secure_type secure_i,
    input wire logic prot_ctrl_err_i,
    output logic misuse_exception_o,
    output logic security_violation_exception_o,
    output logic bus_error_exception_o,
    output logic escalated_fault_exception_o,
    output logic irq_o
);
    logic misuse_fault_enable;
    logic security_fault_enable;
    logic divide_zero_trap_enable;
    logic [usfs_pkg::NIRQ-1:0] irq_enable;
    logic [usfs_pkg::NIRQ-1:0] irq_status;
    logic [usfs_pkg::NIRQ-1:0] irq_set;
    logic [usfs_pkg::NIRQ-1:0] irq_clr;
    logic [usfs_pkg::NCAUSE-1:0] cause_set;
    logic [usfs_pkg::NCAUSE-1:0] cause_clr;
    logic [usfs_pkg::NCAUSE-1:0] cause_q;
    logic [usfs_pkg::DATA_W-1:0] fault_stat_word;
    logic [usfs_pkg::DATA_W-1:0] next_prdata;
    logic next_slverr;
    logic setup;
    logic wr_acc;
    logic misuse_evt;
    logic sec_evt;
    logic next_misuse_exc;
    logic next_sec_exc;
    logic next_escal;

    // APB phases
    assign setup = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;

    // Cause detection
    always_comb begin
        cause_set = '0;
        cause_set[usfs_pkg::CI_DIVZ] = misuse_i.div_zero && divide_zero_trap_enable;
        cause_set[usfs_pkg::CI_UNAL] = misuse_i.unaligned_multi;
        cause_set[usfs_pkg::CI_STACK] = misuse_i.stack_limit;
        cause_set[usfs_pkg::CI_COPROC] = misuse_i.coproc_absent;
        cause_set[usfs_pkg::CI_BADRET] = misuse_i.bad_return;
        // Both the unsupported state and the stale continuable bits land here
        cause_set[usfs_pkg::CI_STATE] = misuse_i.bad_state
            || (misuse_i.cont_bits_nonzero && !misuse_i.next_is_multi);
        cause_set[usfs_pkg::CI_UNDEF] = misuse_i.undefined_opcode;
    end

    // Write-one-to-clear decode of the cause flags
    always_comb begin
        cause_clr = '0;
        for (int k = 0; k < usfs_pkg::NCAUSE; k++) begin
            cause_clr[k] = wr_acc && (paddr_i == usfs_pkg::OFF_FAULT_STAT)
                && pwdata_i[usfs_pkg::CAUSE_BIT[k]];
        end
    end

    generate
        for (genvar g = 0; g < usfs_pkg::NCAUSE; g++) begin : g_cause
            usfs_sticky u_flag (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .set_i(cause_set[g]),
                .clr_i(cause_clr[g]),
                .q_o(cause_q[g])
            );
        end
    endgenerate

    always_comb begin
        fault_stat_word = usfs_pkg::RD_ZERO;
        for (int k = 0; k < usfs_pkg::NCAUSE; k++) begin
            fault_stat_word[usfs_pkg::CAUSE_BIT[k]] = cause_q[k];
        end
    end

    // Exception routing
    assign misuse_evt = |cause_set;
    // Security causes are dropped entirely when the extension is absent
    assign sec_evt = SEC_IMPL && (|secure_i);
    assign next_misuse_exc = misuse_evt && misuse_fault_enable;
    assign next_sec_exc = sec_evt && security_fault_enable;
    assign next_escal = (misuse_evt && !misuse_fault_enable)
        || (sec_evt && !security_fault_enable);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            misuse_exception_o <= 1'b0;
            security_violation_exception_o <= 1'b0;
            escalated_fault_exception_o <= 1'b0;
            bus_error_exception_o <= 1'b0;
        end else begin
            misuse_exception_o <= next_misuse_exc;
            security_violation_exception_o <= next_sec_exc;
            escalated_fault_exception_o <= next_escal;
            // Filtered accesses come back as bus errors, never as security faults
            bus_error_exception_o <= prot_ctrl_err_i;
        end
    end

    // Enable registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            misuse_fault_enable <= 1'b0;
            security_fault_enable <= 1'b0;
        end else if (wr_acc && paddr_i == usfs_pkg::OFF_HANDLER_CTRL) begin
            misuse_fault_enable <= pwdata_i[usfs_pkg::BIT_MISUSE_EN];
            // Stays zero without the extension, so the enable has no effect
            security_fault_enable <= SEC_IMPL && pwdata_i[usfs_pkg::BIT_SEC_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            divide_zero_trap_enable <= 1'b0;
        end else if (wr_acc && paddr_i == usfs_pkg::OFF_CTRL) begin
            divide_zero_trap_enable <= pwdata_i[usfs_pkg::BIT_TRAP_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_enable <= '0;
        end else if (wr_acc && paddr_i == usfs_pkg::OFF_IRQ_EN) begin
            irq_enable <= pwdata_i[usfs_pkg::NIRQ-1:0];
        end
    end

    // Interrupt status
    always_comb begin
        irq_set = '0;
        irq_set[usfs_pkg::IRQ_MISUSE] = next_misuse_exc;
        irq_set[usfs_pkg::IRQ_SECURE] = next_sec_exc;
        irq_set[usfs_pkg::IRQ_ESCAL] = next_escal;
        irq_set[usfs_pkg::IRQ_BUSERR] = prot_ctrl_err_i;
        irq_clr = '0;
        if (wr_acc && paddr_i == usfs_pkg::OFF_IRQ_CLR) begin
            irq_clr = pwdata_i[usfs_pkg::NIRQ-1:0];
        end
    end

    generate
        for (genvar g = 0; g < usfs_pkg::NIRQ; g++) begin : g_irq
            usfs_sticky u_flag (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .set_i(irq_set[g]),
                .clr_i(irq_clr[g]),
                .q_o(irq_status[g])
            );
        end
    endgenerate

    // Registered, so the line follows the status by one cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb begin
        next_prdata = usfs_pkg::RD_ZERO;
        next_slverr = 1'b0;
        unique case (paddr_i)
            usfs_pkg::OFF_FAULT_STAT: begin
                next_prdata = fault_stat_word;
            end
            usfs_pkg::OFF_HANDLER_CTRL: begin
                next_prdata[usfs_pkg::BIT_MISUSE_EN] = misuse_fault_enable;
                next_prdata[usfs_pkg::BIT_SEC_EN] = security_fault_enable;
            end
            usfs_pkg::OFF_CTRL: begin
                next_prdata[usfs_pkg::BIT_TRAP_EN] = divide_zero_trap_enable;
            end
            usfs_pkg::OFF_IRQ_STAT: begin
                next_prdata[usfs_pkg::NIRQ-1:0] = irq_status;
            end
            usfs_pkg::OFF_IRQ_CLR: begin
                next_prdata = usfs_pkg::RD_ZERO;
            end
            usfs_pkg::OFF_IRQ_EN: begin
                next_prdata[usfs_pkg::NIRQ-1:0] = irq_enable;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    // Fixed one-cycle access phase: ready rises in the first access cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= usfs_pkg::RD_ZERO;
        end else begin
            pready_o <= setup;
            if (setup) begin
                pslverr_o <= next_slverr;
                prdata_o <= pwrite_i ? usfs_pkg::RD_ZERO : next_prdata;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_divz_set: assert property (
        misuse_i.div_zero && divide_zero_trap_enable
        |=> cause_q[usfs_pkg::CI_DIVZ])
        else $error("divide flag missed with trap on");

    chk_divz_gated: assert property (
        misuse_i.div_zero && !divide_zero_trap_enable
        && !cause_q[usfs_pkg::CI_DIVZ]
        |=> !cause_q[usfs_pkg::CI_DIVZ])
        else $error("divide flag set with trap off");

    chk_unaligned_set: assert property (
        misuse_i.unaligned_multi |=> cause_q[usfs_pkg::CI_UNAL])
        else $error("unaligned flag not set");

    chk_stack_set: assert property (
        misuse_i.stack_limit |=> cause_q[usfs_pkg::CI_STACK])
        else $error("stack limit flag not set");

    chk_coproc_set: assert property (
        misuse_i.coproc_absent |=> cause_q[usfs_pkg::CI_COPROC])
        else $error("coprocessor flag not set");

    chk_badret_set: assert property (
        misuse_i.bad_return |=> cause_q[usfs_pkg::CI_BADRET])
        else $error("return code flag not set");

    chk_state_set: assert property (
        misuse_i.bad_state |=> cause_q[usfs_pkg::CI_STATE])
        else $error("state flag not set");

    chk_cont_bits: assert property (
        misuse_i.cont_bits_nonzero && !misuse_i.next_is_multi
        |=> cause_q[usfs_pkg::CI_STATE])
        else $error("continuable bits case missed");

    chk_undef_set: assert property (
        misuse_i.undefined_opcode |=> cause_q[usfs_pkg::CI_UNDEF])
        else $error("undefined opcode flag not set");

    chk_sticky_clear: assert property (
        $fell(cause_q[usfs_pkg::CI_STACK])
        |-> $past(wr_acc && paddr_i == usfs_pkg::OFF_FAULT_STAT
        && pwdata_i[usfs_pkg::CAUSE_BIT[usfs_pkg::CI_STACK]]))
        else $error("flag dropped without a one written");

    chk_sticky_hold: assert property (
        cause_q[usfs_pkg::CI_UNDEF] && !(wr_acc
        && paddr_i == usfs_pkg::OFF_FAULT_STAT)
        |=> cause_q[usfs_pkg::CI_UNDEF])
        else $error("flag lost without a write");

    chk_misuse_take: assert property (
        misuse_evt && misuse_fault_enable
        |=> misuse_exception_o && !escalated_fault_exception_o)
        else $error("enabled misuse fault not taken");

    chk_misuse_gate: assert property (
        misuse_exception_o |-> $past(misuse_fault_enable))
        else $error("misuse fault taken while disabled");

    chk_sec_take: assert property (
        sec_evt && security_fault_enable
        |=> security_violation_exception_o)
        else $error("enabled security fault not taken");

    chk_sec_cause: assert property (
        secure_i.perm_violation && SEC_IMPL && security_fault_enable
        |=> security_violation_exception_o)
        else $error("permission break not reported");

    chk_sec_integrity: assert property (
        secure_i.integrity_fail && SEC_IMPL && !security_fault_enable
        |=> escalated_fault_exception_o)
        else $error("integrity failure not escalated");

    chk_sec_absent: assert property (
        !SEC_IMPL |-> !security_violation_exception_o
        && !security_fault_enable)
        else $error("security fault without extension");

    chk_bus_route: assert property (
        prot_ctrl_err_i && !sec_evt
        |=> bus_error_exception_o && !security_violation_exception_o)
        else $error("protection error routed wrongly");

    chk_escalate: assert property (
        misuse_evt && !misuse_fault_enable
        |=> escalated_fault_exception_o && !misuse_exception_o)
        else $error("disabled misuse fault not escalated");

    chk_apb_ready: assert property (
        setup |=> pready_o ##1 (!pready_o || (psel_i && !penable_i)))
        else $error("apb ready timing wrong");

    // A clear landing with a new event must not lose the event
    chk_set_wins: assert property (
        cause_set[usfs_pkg::CI_UNAL] && cause_clr[usfs_pkg::CI_UNAL]
        |=> cause_q[usfs_pkg::CI_UNAL])
        else $error("clear beat a same-cycle set");

    chk_irq_level: assert property (
        irq_o == $past(|(irq_status & irq_enable)))
        else $error("interrupt line does not follow enabled status");

    chk_bus_pulse: assert property (
        bus_error_exception_o |-> $past(prot_ctrl_err_i))
        else $error("bus error without a protection error");

    cov_misuse_taken: cover property (
        misuse_evt && misuse_fault_enable ##1 misuse_exception_o);

    cov_escalated: cover property (
        sec_evt && !security_fault_enable ##1 escalated_fault_exception_o);

    cov_set_and_clear: cover property (
        cause_clr[usfs_pkg::CI_UNAL] && cause_set[usfs_pkg::CI_UNAL]);

    cov_irq: cover property (
        $rose(irq_o));
endmodule
